// *** hw/part_ctl.sv ***
// Partition control and status register bank with delayed secondary reset.
// Assumes one AHB-Lite master, word transfers, inputs synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module part_ctl #(
    parameter int change_cycles = part_ctl_pkg::change_cycles
) (
    // AHB-Lite slave
    input  wire  logic        hclk,
    input  wire  logic        hresetn,
    input  wire  logic        hsel,
    input  wire  logic [11:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic        hready,
    input  wire  logic [31:0] hwdata,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Boot strap and partition topology
    input  wire  logic [1:0]  boot_part_state,
    input  wire  logic        us_assigned,
    input  wire  logic [3:0]  us_port_id,
    // Upstream link and reset requests
    input  wire  logic        us_dl_down,
    input  wire  logic        sbr_request,
    output logic              us_hot_reset,
    output logic              ds_hot_reset,
    output logic              sbr_start,
    output logic [1:0]        part_state,
    // Interrupt
    output logic              irq
);
    initial begin
        if (change_cycles < 1 || change_cycles > 255) begin
            $error("change_cycles out of range");
        end
        // The microsecond prescaler is only eight bits wide
        if (part_ctl_pkg::cycles_per_us < 1
            || part_ctl_pkg::cycles_per_us > 256) begin
            $error("cycles_per_us out of range");
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic        boot_taken;
        logic        wr_pend;
        logic        rd_pend;
        logic [11:0] addr;
        logic [15:0] sbr_delay;
        logic [1:0]  req_state;
        logic        inhibit;
        logic [1:0]  cur_state;
        logic        busy;
        logic [7:0]  chg_cnt;
        logic        started;
        logic        done;
        logic        sbr_busy;
        logic [15:0] us_cnt;
        logic [7:0]  tick_cnt;
        logic        sbr_pulse;
        logic        us_hot;
        logic        ds_hot;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_mask;
        logic [31:0] rdata;
    } state_type;

    state_type st_reg;
    state_type st_next;

    logic        addr_ph;
    logic [31:0] wmask;
    logic [2:0]  irq_set;
    logic        sw_state_wr;
    logic        start_now;

    // Address phase taken only while the bus is ready
    assign addr_ph   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata;
    assign irq       = |(st_reg.irq_sts & ~st_reg.irq_mask); // Set bit hides
    assign us_hot_reset = st_reg.us_hot;
    assign ds_hot_reset = st_reg.ds_hot;
    assign sbr_start    = st_reg.sbr_pulse;
    assign part_state   = st_reg.cur_state;
    assign wmask        = hwdata;

    // Read mux, decode shared by reads only
    function automatic logic [31:0] read_word(input state_type s,
                                              input logic [11:0] a,
                                              input logic us_a,
                                              input logic [3:0] us_id);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == part_ctl_pkg::sbr_start_delay_off) begin
            r[15:0] = s.sbr_delay;
        end else if (a == part_ctl_pkg::partition_control_off) begin
            r[part_ctl_pkg::ctl_state_lsb +: 2] = s.req_state;
            r[part_ctl_pkg::ctl_inhibit_bit]    = s.inhibit;
        end else if (a == part_ctl_pkg::partition_status_off) begin
            r[part_ctl_pkg::sts_started_bit] = s.started;
            r[part_ctl_pkg::sts_done_bit]    = s.done;
            r[part_ctl_pkg::sts_has_us_bit]  = us_a;
            if (us_a) begin
                r[part_ctl_pkg::sts_us_num_lsb +: 4] = us_id;
            end
            r[part_ctl_pkg::sts_cur_lsb +: 2] = s.cur_state;
        end else if (a == part_ctl_pkg::irq_status_off) begin
            r[2:0] = s.irq_sts;
        end else if (a == part_ctl_pkg::irq_mask_off) begin
            r[2:0] = s.irq_mask;
        end
        return r;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        irq_set = 3'h0;
        sw_state_wr = 1'b0;
        st_next.sbr_pulse = 1'b0;
        st_next.us_hot = 1'b0;
        st_next.ds_hot = 1'b0;
        // Strap caught one cycle after reset release
        if (!st_reg.boot_taken) begin
            st_next.boot_taken = 1'b1;
            st_next.req_state  = boot_part_state;
            st_next.cur_state  = boot_part_state;
        end
        // Read data registered for the data phase
        st_next.rd_pend = addr_ph && !hwrite;
        st_next.wr_pend = addr_ph && hwrite;
        if (addr_ph) begin
            st_next.addr = haddr;
        end
        if (addr_ph && !hwrite) begin
            st_next.rdata = read_word(st_reg, haddr, us_assigned, us_port_id);
        end
        // Write data phase
        if (st_reg.wr_pend) begin
            if (st_reg.addr == part_ctl_pkg::sbr_start_delay_off) begin
                st_next.sbr_delay = wmask[15:0];
            end else if (st_reg.addr == part_ctl_pkg::partition_control_off) begin
                // Reserved code is refused; the field keeps its value
                if (wmask[1:0] != part_ctl_pkg::part_reserved) begin
                    st_next.req_state = wmask[1:0];
                    sw_state_wr = (wmask[1:0] != st_reg.req_state);
                end
                st_next.inhibit = wmask[part_ctl_pkg::ctl_inhibit_bit];
            end else if (st_reg.addr == part_ctl_pkg::partition_status_off) begin
                if (wmask[part_ctl_pkg::sts_started_bit]) begin
                    st_next.started = 1'b0;
                end
                if (wmask[part_ctl_pkg::sts_done_bit]) begin
                    st_next.done = 1'b0;
                end
            end else if (st_reg.addr == part_ctl_pkg::irq_status_off) begin
                st_next.irq_sts = st_reg.irq_sts & ~wmask[2:0];
            end else if (st_reg.addr == part_ctl_pkg::irq_mask_off) begin
                st_next.irq_mask = wmask[2:0];
            end
        end
        // State change sequencing; a new request restarts the timer
        if (sw_state_wr) begin
            st_next.started = 1'b1;
            st_next.busy    = 1'b1;
            st_next.chg_cnt = 8'(change_cycles);
            irq_set[part_ctl_pkg::irq_started_bit] = 1'b1;
        end else if (st_reg.busy) begin
            if (st_reg.chg_cnt <= 8'h01) begin
                st_next.busy      = 1'b0;
                st_next.cur_state = st_reg.req_state;
                st_next.done      = 1'b1;
                irq_set[part_ctl_pkg::irq_done_bit] = 1'b1;
            end else begin
                st_next.chg_cnt = st_reg.chg_cnt - 8'h01;
            end
        end
        // Secondary bus reset delay timer, microsecond ticks
        start_now = 1'b0;
        if (sbr_request && !st_reg.sbr_busy) begin
            if (st_reg.sbr_delay == 16'h0000) begin
                start_now = 1'b1;
            end else begin
                st_next.sbr_busy = 1'b1;
                st_next.us_cnt   = st_reg.sbr_delay;
                st_next.tick_cnt = 8'(part_ctl_pkg::cycles_per_us - 1);
            end
        end else if (st_reg.sbr_busy) begin
            if (st_reg.tick_cnt == 8'h00) begin
                st_next.tick_cnt = 8'(part_ctl_pkg::cycles_per_us - 1);
                if (st_reg.us_cnt == 16'h0001) begin
                    st_next.sbr_busy = 1'b0;
                    start_now = 1'b1;
                end else begin
                    st_next.us_cnt = st_reg.us_cnt - 16'h0001;
                end
            end else begin
                st_next.tick_cnt = st_reg.tick_cnt - 8'h01;
            end
        end
        if (start_now) begin
            st_next.sbr_pulse = 1'b1;
            irq_set[part_ctl_pkg::irq_sbr_bit] = 1'b1;
        end
        // Link-down hot reset; link layers are never touched here
        if (us_dl_down && !st_reg.inhibit) begin
            st_next.us_hot = 1'b1;
            st_next.ds_hot = 1'b1;
        end
        // Set wins over clear for interrupt status
        st_next.irq_sts = st_next.irq_sts | irq_set;
    end

    // Single register for all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Secondary reset timing
    zero_delay_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sbr_request && !st_reg.sbr_busy && st_reg.sbr_delay == 16'h0000
        |=> sbr_start) else $error("zero delay did not start reset");
    delay_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sbr_request && !st_reg.sbr_busy && st_reg.sbr_delay != 16'h0000
        |=> !sbr_start [*8]) else $error("reset started early");

    // Link-down hot reset gating
    inhibit_us_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        us_dl_down && st_reg.inhibit |=> !us_hot_reset)
        else $error("upstream hot reset despite inhibit");
    inhibit_ds_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        us_dl_down && st_reg.inhibit |=> !ds_hot_reset)
        else $error("downstream hot reset despite inhibit");
    hot_reset_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        us_dl_down && !st_reg.inhibit |=> us_hot_reset && ds_hot_reset)
        else $error("link down gave no hot reset");

    // Partition state change flags
    started_set_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sw_state_wr |=> st_reg.started && st_reg.busy)
        else $error("started flag not set");
    done_set_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sw_state_wr |-> ##[1:256] st_reg.done)
        else $error("done flag not set");
    state_match_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(st_reg.done) |-> part_state == st_reg.req_state)
        else $error("current state not updated");
    no_reserved_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_reg.wr_pend && st_reg.addr == part_ctl_pkg::partition_control_off
        && hwdata[1:0] == part_ctl_pkg::part_reserved
        |=> $stable(st_reg.req_state))
        else $error("reserved state accepted");

    // Interrupt status: a hardware set survives a same-cycle clear
    irq_kept_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq_set != 3'h0
        |=> (st_reg.irq_sts & $past(irq_set)) == $past(irq_set))
        else $error("interrupt status lost");

    // Main scenarios
    change_c: cover property (@(posedge hclk) sw_state_wr ##[1:16] st_reg.done);
    sbr_c:    cover property (@(posedge hclk) st_reg.sbr_busy ##1 sbr_start);
    inhib_c:  cover property (@(posedge hclk) us_dl_down && st_reg.inhibit);
    hot_c:    cover property (@(posedge hclk) us_hot_reset && ds_hot_reset);
    irq_c:    cover property (@(posedge hclk) irq);
endmodule
`default_nettype wire

// *** inc/part_ctl_pkg.sv ***
// Package for the switch partition control register bank.
// Assumes AHB-Lite word access, 32-bit data, one partition per instance.
package part_ctl_pkg;
    // Register byte offsets
    localparam logic [11:0] sbr_start_delay_off   = 12'h08c;
    localparam logic [11:0] partition_control_off = 12'h100;
    localparam logic [11:0] partition_status_off  = 12'h104;
    localparam logic [11:0] irq_status_off        = 12'h108;
    localparam logic [11:0] irq_mask_off          = 12'h10c;
    localparam logic [11:0] link_events_off       = 12'h110;

    // Partition control fields
    localparam int ctl_state_lsb   = 0;
    localparam int ctl_inhibit_bit = 2;

    // Partition status fields
    localparam int sts_started_bit = 0;
    localparam int sts_done_bit    = 1;
    localparam int sts_has_us_bit  = 4;
    localparam int sts_us_num_lsb  = 5;
    localparam int sts_cur_lsb     = 9;

    // Interrupt bits
    localparam int irq_started_bit = 0;
    localparam int irq_done_bit    = 1;
    localparam int irq_sbr_bit     = 2;
    localparam int irq_width       = 3;

    // Partition state encodings
    typedef enum logic [1:0] {
        part_disabled = 2'h0,
        part_active   = 2'h1,
        part_reserved = 2'h2,
        part_reset    = 2'h3
    } part_state_type;

    // Delay timebase
    localparam int clock_mhz      = 200;
    localparam int cycles_per_us  = clock_mhz;
    localparam int sbr_delay_bits = 16;
    localparam int change_cycles  = 4;
endpackage

// *** tb/testbench.sv ***
// Self-checking bench for the partition control register bank.
// Assumes an AHB-Lite single master and the upstream link model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ********************
    // Signals and model state
    // ********************
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        us_assigned, us_dl_down, sbr_request, sbr_start;
    logic        us_hot_reset, ds_hot_reset;
    logic [11:0] haddr;
    logic [1:0]  htrans, boot_part_state, part_state;
    logic [2:0]  hsize;
    logic [3:0]  us_port_id;
    logic [31:0] hwdata, hrdata, rd, rnd;
    int          n_mismatch, cmp_count, n, exp_state;
    int          codes[$] = '{3, 0, 1};

    part_ctl #(.change_cycles(4)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .boot_part_state(boot_part_state), .us_assigned(us_assigned),
        .us_port_id(us_port_id), .us_dl_down(us_dl_down),
        .sbr_request(sbr_request), .us_hot_reset(us_hot_reset),
        .ds_hot_reset(ds_hot_reset), .sbr_start(sbr_start),
        .part_state(part_state), .irq(irq));
    up_link_model link_u (
        .hclk(hclk), .us_dl_down(us_dl_down), .sbr_request(sbr_request),
        .us_assigned(us_assigned), .us_port_id(us_port_id),
        .boot_part_state(boot_part_state));

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ********************
    // Tasks
    // ********************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Single word transfer; waits on hready, read data lands in rd
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Time from a reset request to the start pulse, in cycles
    task automatic sbr_gap(input int us);
        link_u.pulse(1'b1);
        #1;
        n = 0;
        while (sbr_start !== 1'b1 && n < 2000) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk("sbr_gap", 32'(n >= us * 200 && n <= us * 200 + 2), 32'h1);
        @(posedge hclk);
        #1;
        chk("sbr_pulse", 32'(sbr_start), 32'h0);
    endtask
    task automatic end_of_test;
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        rnd = 32'h00016699;
        n_mismatch = 0;
        cmp_count = 0;
        exp_state = 1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(0, part_ctl_pkg::sbr_start_delay_off, 0);
        chk("delay_rst", rd, 32'h0);
        bus(0, part_ctl_pkg::partition_control_off, 0);
        chk("ctl_boot", rd & 3, exp_state);
        bus(0, part_ctl_pkg::partition_status_off, 0);
        chk("sts_boot", rd & 32'h7f0, 32'h2b0);
        bus(1, part_ctl_pkg::irq_mask_off, 0);
        sbr_gap(0);
        // Delay only ever raised here
        bus(1, part_ctl_pkg::sbr_start_delay_off, 1);
        sbr_gap(1);
        rnd = lfsr(rnd);
        bus(1, part_ctl_pkg::sbr_start_delay_off, rnd | 1);
        bus(0, part_ctl_pkg::sbr_start_delay_off, 0);
        chk("delay_fld", rd, (rnd | 1) & 32'hffff);
        chk("irq_sbr", 32'(irq), 32'h1);
        // Each legal state code, flags cleared between steps
        foreach (codes[i]) begin
            bus(1, part_ctl_pkg::partition_control_off, codes[i]);
            bus(0, part_ctl_pkg::partition_status_off, 0);
            chk("started", rd & 3, 32'h1);
            repeat (8) @(posedge hclk);
            exp_state = codes[i];
            bus(0, part_ctl_pkg::partition_status_off, 0);
            chk("done", rd & 32'h603, exp_state << 9 | 3);
            chk("state", 32'(part_state), exp_state);
            bus(1, part_ctl_pkg::partition_status_off, 3);
            bus(0, part_ctl_pkg::partition_status_off, 0);
            chk("w1c", rd & 3, 32'h0);
        end
        bus(1, part_ctl_pkg::partition_control_off, 2);
        repeat (8) @(posedge hclk);
        bus(0, part_ctl_pkg::partition_status_off, 0);
        chk("rsvd_code", rd & 32'h603, exp_state << 9);
        // Interrupt status, mask and clear
        bus(0, part_ctl_pkg::irq_status_off, 0);
        chk("irq_sts", rd & 7, 32'h7);
        bus(1, part_ctl_pkg::irq_mask_off, 7);
        #1 chk("irq_masked", 32'(irq), 32'h0);
        bus(1, part_ctl_pkg::irq_mask_off, 0);
        #1 chk("irq_open", 32'(irq), 32'h1);
        bus(1, part_ctl_pkg::irq_status_off, 7);
        #1 chk("irq_clr", 32'(irq), 32'h0);
        // Link down with and without the inhibit bit
        link_u.pulse(1'b0);
        #1 chk("hot_rst", {us_hot_reset, ds_hot_reset}, 32'h3);
        bus(1, part_ctl_pkg::partition_control_off, exp_state | 4);
        bus(0, part_ctl_pkg::partition_control_off, 0);
        chk("inhibit", rd & 7, exp_state | 4);
        link_u.pulse(1'b0);
        #1 chk("hot_inh", {us_hot_reset, ds_hot_reset}, 32'h0);
        // Topology follows the link side
        rnd = lfsr(rnd);
        link_u.topo(1'b1, rnd[3:0]);
        bus(0, part_ctl_pkg::partition_status_off, 0);
        chk("us_id", rd & 32'h1f0, 32'h10 | rnd[3:0] << 5);
        link_u.topo(1'b0, rnd[3:0]);
        bus(0, part_ctl_pkg::partition_status_off, 0);
        chk("no_us", rd & 32'h1f0, 32'h0);
        bus(1, 12'h200, rnd);
        bus(0, 12'h200, 0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        end_of_test;
    end
    // Watchdog, well beyond the expected run
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        end_of_test;
    end
endmodule
`default_nettype wire

// *** tb/up_link_model.sv ***
// Far-side model: upstream link events, topology and boot strap.
// Assumes the bench calls its tasks from a process clocked by hclk.
`timescale 1ns/10ps
`default_nettype none
module up_link_model (
    // Clock
    input  wire logic       hclk,
    // Link events and topology
    output var  logic       us_dl_down,
    output var  logic       sbr_request,
    output var  logic       us_assigned,
    output var  logic [3:0] us_port_id,
    output var  logic [1:0] boot_part_state
);
    // Quiet link, port 5 upstream, partition boots active
    initial begin
        us_dl_down      = 1'b0;
        sbr_request     = 1'b0;
        us_assigned     = 1'b1;
        us_port_id      = 4'h5;
        boot_part_state = 2'h1;
    end
    // One-cycle event pulse, launched and dropped just after edges
    task automatic pulse(input logic sbr);
        @(posedge hclk);
        sbr_request <= sbr;
        us_dl_down  <= ~sbr;
        @(posedge hclk);
        sbr_request <= 1'b0;
        us_dl_down  <= 1'b0;
    endtask
    // Reassign the upstream port of the partition
    task automatic topo(input logic a, input logic [3:0] id);
        @(posedge hclk);
        us_assigned <= a;
        us_port_id  <= id;
    endtask
endmodule
`default_nettype wire
